//--- rtl/gt_timer.sv
`include "gt_params.svh"

module gt_timer
    import gt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire gt_cfg_s cfg,
    input wire gt_bus_s bus,
    input wire logic external_clock_pin,
    input wire logic lp_osc_pin,
    input wire logic gate_signal,
    input wire logic sleep,
    input wire logic overflow_clear,
    output logic [7:0] reg_rdata_r,
    output logic [15:0] count_value_r,
    output logic overflow_flag_r,
    output logic wake_r
);

    // ************************************************
    // functions
    // ************************************************
    function automatic logic [2:0] ps_mask(input logic [1:0] sel);
        ps_mask = 3'((4'h1 << sel) - 4'h1);
    endfunction

    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur && !prev;
    endfunction

    function automatic logic fall_of(input logic cur, input logic prev);
        fall_of = !cur && prev;
    endfunction

    // ************************************************
    // state
    // ************************************************
    logic [1:0] phase_r;
    logic [2:0] ps_r;
    logic [2:0] ps_nxt;
    logic [15:0] count_value_nxt;
    logic [7:0] high_buf_r;
    logic [7:0] high_buf_nxt;
    logic [7:0] reg_rdata_nxt;
    logic overflow_flag_nxt;
    logic wake_nxt;
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic async_prev_r;
    logic armed_r;
    logic armed_nxt;

    // ************************************************
    // decoding
    // ************************************************
    wire wr_lo = bus.wr && (bus.sel == `GT_SEL_LOW);
    wire wr_hi = bus.wr && (bus.sel == `GT_SEL_HIGH);
    wire rd_lo = bus.rd && (bus.sel == `GT_SEL_LOW);
    wire rd_hi = bus.rd && (bus.sel == `GT_SEL_HIGH);
    wire wide = cfg.wide_access_enable;
    wire cnt_load = wr_lo || (wr_hi && !wide);
    wire ext_src = (cfg.clk_src == GT_SRC_EXT) || (cfg.clk_src == GT_SRC_LPOSC);
    wire ext_lvl = (cfg.clk_src == GT_SRC_EXT) ? external_clock_pin : lp_osc_pin;
    // sync path: s1 feeds only s2; edges taken from s2/s3
    wire rise_sync = !sleep && rise_of(sync2_r, sync3_r);
    wire fall_sync = !sleep && fall_of(sync2_r, sync3_r);
    wire rise_async = rise_of(ext_lvl, async_prev_r);
    wire fall_async = fall_of(ext_lvl, async_prev_r);
    wire ext_rise = cfg.skip_sync ? rise_async : rise_sync;
    wire ext_fall = cfg.skip_sync ? fall_async : fall_sync;
    wire gate_ok = !cfg.gate_enable || (gate_signal == cfg.gate_polarity);
    wire count_ok = cfg.run && gate_ok;
    // internal sources ignore skip-sync and stop in sleep
    wire instr_tick = !sleep && (phase_r == `GT_PHASE_LAST);
    wire raw_tick = !sleep;
    wire ext_tick = armed_r && ext_rise;
    wire src_tick = (cfg.clk_src == GT_SRC_INSTR) ? instr_tick :
                    (cfg.clk_src == GT_SRC_RAW) ? raw_tick : ext_tick;
    wire tick = count_ok && src_tick;
    wire ps_match = (ps_r & ps_mask(cfg.prescale_select)) == ps_mask(cfg.prescale_select);
    wire inc = tick && ps_match;
    wire ovf_set = inc && !cnt_load && (count_value_r == `GT_CNT_TOP);
    wire [15:0] load_val = wr_lo ? {(wide ? high_buf_r : count_value_r[15:8]), bus.wdata}
                                 : {bus.wdata, count_value_r[7:0]};
    wire [7:0] hi_view = wide ? high_buf_r : count_value_r[15:8];

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        if (cnt_load) begin
            count_value_nxt = load_val;
        end else if (inc) begin
            count_value_nxt = count_value_r + 16'h0001;
        end else begin
            count_value_nxt = count_value_r;
        end
    end

    always_comb begin
        if (wr_lo || (wr_hi && !wide)) begin
            ps_nxt = `GT_PS_RST;
        end else if (tick) begin
            ps_nxt = ps_match ? `GT_PS_RST : ps_r + 3'h1;
        end else begin
            ps_nxt = ps_r;
        end
    end

    always_comb begin
        if (wide && wr_hi) begin
            high_buf_nxt = bus.wdata;
        end else if (wide && rd_lo) begin
            high_buf_nxt = count_value_r[15:8];
        end else begin
            high_buf_nxt = high_buf_r;
        end
    end

    always_comb begin
        if (rd_lo) begin
            reg_rdata_nxt = count_value_r[7:0];
        end else if (rd_hi) begin
            reg_rdata_nxt = hi_view;
        end else begin
            reg_rdata_nxt = reg_rdata_r;
        end
    end

    always_comb begin
        // counter-mode arming: cleared when off or written
        if (!cfg.run || cnt_load) begin
            armed_nxt = 1'b0;
        end else if (ext_fall) begin
            armed_nxt = 1'b1;
        end else begin
            armed_nxt = armed_r;
        end
    end

    // set wins over clear
    assign overflow_flag_nxt = ovf_set || (overflow_flag_r && !overflow_clear);
    assign wake_nxt = ovf_set && sleep;

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 2'h0;
            ps_r <= `GT_PS_RST;
            count_value_r <= `GT_CNT_RST;
            high_buf_r <= `GT_BYTE_RST;
            reg_rdata_r <= `GT_BYTE_RST;
            overflow_flag_r <= 1'b0;
            wake_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            ps_r <= ps_nxt;
            count_value_r <= count_value_nxt;
            high_buf_r <= high_buf_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            overflow_flag_r <= overflow_flag_nxt;
            wake_r <= wake_nxt;
            armed_r <= armed_nxt;
        end
    end

    // synchroniser holds still while asleep
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            async_prev_r <= 1'b0;
        end else begin
            if (!sleep) begin
                sync1_r <= ext_lvl;
                sync2_r <= sync1_r;
                sync3_r <= sync2_r;
            end
            async_prev_r <= ext_lvl;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    off_hold_a: assert property (
        !cfg.run && !bus.wr |=> count_value_r == $past(count_value_r))
        else $error("count moved while timer off");

    wr_load_a: assert property (
        wr_lo && !wide |=> count_value_r[7:0] == $past(bus.wdata))
        else $error("low write did not load count");

    ovf_wrap_a: assert property (
        inc && !cnt_load && count_value_r == `GT_CNT_TOP |=> count_value_r == `GT_CNT_RST && overflow_flag_r)
        else $error("rollover or overflow flag wrong");

    ps_clear_a: assert property (
        wr_lo |=> ps_r == `GT_PS_RST)
        else $error("prescaler not cleared by low write");

    hi_keep_a: assert property (
        wide && wr_hi && !tick |=> ps_r == $past(ps_r) && high_buf_r == $past(bus.wdata))
        else $error("buffered high write disturbed prescaler");

    rd_latch_a: assert property (
        wide && rd_lo && !bus.wr ##1 rd_hi && !bus.wr |=> reg_rdata_r == $past(count_value_r[15:8], 2))
        else $error("high read not from latched buffer");

    wide_wr_a: assert property (
        wide && wr_lo |=> count_value_r == {$past(high_buf_r), $past(bus.wdata)})
        else $error("wide write not loaded as one word");

    gate_hold_a: assert property (
        cfg.gate_enable && gate_signal != cfg.gate_polarity && !bus.wr
        |=> count_value_r == $past(count_value_r))
        else $error("count moved with gate inactive");

    arm_need_a: assert property (
        ext_src && !armed_r && !bus.wr |=> count_value_r == $past(count_value_r))
        else $error("counted before falling edge seen");

    div_ratio_a: assert property (
        count_value_r != $past(count_value_r) && !$past(bus.wr) |-> $past(ps_match && tick))
        else $error("increment without prescaler terminal count");

    sleep_stop_a: assert property (
        sleep && !ext_src && !bus.wr |=> count_value_r == $past(count_value_r))
        else $error("internal clock counted in sleep");

    instr_rate_a: assert property (
        cfg.clk_src == GT_SRC_INSTR && !sleep && phase_r != `GT_PHASE_LAST && !bus.wr
        |=> count_value_r == $past(count_value_r))
        else $error("instruction clock counted off phase");

    sync_sleep_a: assert property (
        sleep && ext_src && !cfg.skip_sync && !bus.wr
        |=> count_value_r == $past(count_value_r))
        else $error("synchronised input counted in sleep");

    wake_set_a: assert property (
        ovf_set && sleep |=> wake_r)
        else $error("overflow in sleep gave no wake pulse");

    wake_only_a: assert property (
        !sleep |=> !wake_r)
        else $error("wake pulse while awake");

    flag_hold_a: assert property (
        overflow_flag_r && !overflow_clear |=> overflow_flag_r)
        else $error("overflow flag dropped without clear");

    flag_clear_a: assert property (
        overflow_clear && !ovf_set |=> !overflow_flag_r)
        else $error("overflow flag not cleared");

    free_run_a: assert property (
        cfg.run && !cfg.gate_enable && cfg.clk_src == GT_SRC_RAW && !sleep && ps_match && !bus.wr
        |=> count_value_r == $past(count_value_r) + 16'h0001)
        else $error("running timer did not count");

    gate_count_a: assert property (
        cfg.run && cfg.gate_enable && gate_signal == cfg.gate_polarity && cfg.clk_src == GT_SRC_RAW
        && !sleep && ps_match && !bus.wr |=> count_value_r == $past(count_value_r) + 16'h0001)
        else $error("active gate did not let count advance");

    hi_direct_a: assert property (
        !wide && wr_hi |=> count_value_r[15:8] == $past(bus.wdata))
        else $error("direct high write not loaded");

    hi_read_a: assert property (
        wide && rd_hi && !bus.wr |=> reg_rdata_r == $past(high_buf_r))
        else $error("buffered high read not from buffer");

    lo_read_a: assert property (
        rd_lo && !bus.wr |=> reg_rdata_r == $past(count_value_r[7:0]))
        else $error("low read returned wrong byte");

    rdata_hold_a: assert property (
        !bus.rd |=> reg_rdata_r == $past(reg_rdata_r))
        else $error("read data changed without read");

    arm_clear_a: assert property (
        cnt_load || !cfg.run |=> !armed_r)
        else $error("arming kept after load or stop");

    ext_count_a: assert property (
        ext_src && armed_r && ext_rise && count_ok && ps_match && !bus.wr
        |=> count_value_r == $past(count_value_r) + 16'h0001)
        else $error("external rising edge not counted");

    ps_hold_a: assert property (
        !tick && !cnt_load |=> ps_r == $past(ps_r))
        else $error("prescaler moved without tick");

    ps_wrap_a: assert property (
        tick && ps_match && !cnt_load |=> ps_r == `GT_PS_RST)
        else $error("prescaler did not wrap at ratio");

    hi_hold_a: assert property (
        !(wide && (wr_hi || rd_lo)) |=> high_buf_r == $past(high_buf_r))
        else $error("high buffer changed unasked");

endmodule

//--- inc/gt_params.svh
`ifndef GT_PARAMS_SVH
`define GT_PARAMS_SVH
`define GT_CNT_RST 16'h0000
`define GT_CNT_TOP 16'hffff
`define GT_BYTE_RST 8'h00
`define GT_PS_RST 3'h0
`define GT_PHASE_LAST 2'h3
`define GT_SEL_LOW 1'b0
`define GT_SEL_HIGH 1'b1
`endif

//--- inc/gt_pkg.sv
package gt_pkg;
    typedef enum logic [1:0] {
        GT_SRC_INSTR,
        GT_SRC_RAW,
        GT_SRC_EXT,
        GT_SRC_LPOSC
    } gt_src_e;

    typedef struct packed {
        logic run;
        logic gate_enable;
        logic gate_polarity;
        logic wide_access_enable;
        logic skip_sync;
        logic [1:0] prescale_select;
        gt_src_e clk_src;
    } gt_cfg_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic sel;
        logic [7:0] wdata;
    } gt_bus_s;
endpackage

//--- tb/gt_ext_src.sv
module gt_ext_src (
    input wire logic sys_clk,
    input wire logic en,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // external count clock, idle low when off
    // ****************************************
    logic [1:0] cnt_r;
    // eight-cycle period; the first edge after enable is a rise
    always @(posedge sys_clk) begin
        if (!en) begin
            cnt_r <= 2'h0;
            pin <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h3) begin
                pin <= ~pin;
            end
        end
    end
endmodule

//--- tb/test_gated_sixteen_bit_timer_counter.sv
module test_gated_sixteen_bit_timer_counter import gt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus and checking
    // ****************************************
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    gt_cfg_s cfg = '0;
    gt_bus_s bus = '0;
    logic ext_en = 1'b0;
    logic gate_signal = 1'b0;
    logic sleep = 1'b0;
    logic ovf_clr = 1'b0;
    logic ext_pin;
    logic lp_en = 1'b0;
    logic lp_pin;
    logic [7:0] rdata;
    logic [15:0] cnt;
    logic ovf;
    logic wake;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #4 sys_clk = ~sys_clk;
    gt_ext_src partner (.sys_clk(sys_clk), .en(ext_en), .pin(ext_pin));
    gt_ext_src lp_partner (.sys_clk(sys_clk), .en(lp_en), .pin(lp_pin));
    gt_timer uut (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg), .bus(bus), .external_clock_pin(ext_pin),
        .lp_osc_pin(lp_pin), .gate_signal(gate_signal), .sleep(sleep), .overflow_clear(ovf_clr),
        .reg_rdata_r(rdata), .count_value_r(cnt), .overflow_flag_r(ovf), .wake_r(wake));
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic acc(input logic w, input logic s, input logic [7:0] d);
        @(negedge sys_clk);
        bus.wr = w;
        bus.rd = ~w;
        bus.sel = s;
        bus.wdata = d;
        @(negedge sys_clk);
        bus.wr = 1'b0;
        bus.rd = 1'b0;
    endtask
    // low read then high read on back-to-back edges
    task automatic rd_pair(output logic [7:0] lo, output logic [7:0] hi);
        @(negedge sys_clk);
        bus.wr = 1'b0;
        bus.rd = 1'b1;
        bus.sel = 1'b0;
        @(negedge sys_clk);
        lo = rdata;
        bus.sel = 1'b1;
        @(negedge sys_clk);
        hi = rdata;
        bus.rd = 1'b0;
    endtask
    // counts advanced over a window of n cycles
    task automatic rate(input int n, input logic [15:0] exp);
        logic [15:0] c0;
        c0 = cnt;
        cyc(n);
        chk(cnt - c0, exp);
    endtask
    task automatic t_rates;
        cfg.run = 1'b1;
        for (int p = 0; p < 4; p++) begin
            cfg.prescale_select = p[1:0];
            cfg.clk_src = GT_SRC_RAW;
            cyc(4);
            rate(32, 16'h20 >> p);
            cfg.clk_src = GT_SRC_INSTR;
            cfg.skip_sync = p[0];
            cyc(4);
            rate(32, 16'h8 >> p);
        end
        cfg.run = 1'b0;
        cyc(2);
        rate(32, 16'h0);
    endtask
    task automatic t_gate;
        cfg = '0;
        cfg.clk_src = GT_SRC_RAW;
        cfg.run = 1'b1;
        cfg.gate_enable = 1'b1;
        for (int p = 0; p < 2; p++) begin
            cfg.gate_polarity = p[0];
            gate_signal = p[0];
            cyc(4);
            rate(16, 16'h10);
            gate_signal = ~p[0];
            cyc(4);
            rate(16, 16'h0);
        end
        cfg.gate_enable = 1'b0;
        cyc(4);
        rate(16, 16'h10);
    endtask
    task automatic t_wide;
        logic [15:0] c0;
        logic [7:0] lo;
        logic [7:0] hi;
        cfg.prescale_select = 2'h3;
        cfg.wide_access_enable = 1'b1;
        c0 = cnt;
        repeat (16) acc(1'b1, 1'b1, 8'h00);
        chk(cnt - c0, 16'h4);
        cfg.run = 1'b0;
        acc(1'b1, 1'b1, 8'h12);
        acc(1'b1, 1'b0, 8'h34);
        chk(cnt, 16'h1234);
        acc(1'b1, 1'b1, 8'h56);
        chk(cnt, 16'h1234);
        rd_pair(lo, hi);
        chk({8'h00, lo}, 16'h34);
        chk({8'h00, hi}, 16'h12);
        cfg.wide_access_enable = 1'b0;
        acc(1'b1, 1'b1, 8'hab);
        chk(cnt, 16'hab34);
    endtask
    task automatic t_ovf;
        cfg.wide_access_enable = 1'b1;
        acc(1'b1, 1'b1, 8'hff);
        acc(1'b1, 1'b0, 8'hff);
        chk({15'h0, ovf}, 16'h0);
        cfg.prescale_select = 2'h0;
        cfg.run = 1'b1;
        cyc(3);
        cfg.run = 1'b0;
        chk({15'h0, ovf}, 16'h1);
        chk({15'h0, cnt < 16'h4}, 16'h1);
        ovf_clr = 1'b1;
        cyc(1);
        ovf_clr = 1'b0;
        chk({15'h0, ovf}, 16'h0);
    endtask
    task automatic t_ext;
        logic [15:0] c0;
        int seen;
        cfg = '0;
        cfg.clk_src = GT_SRC_EXT;
        acc(1'b1, 1'b0, 8'h00);
        c0 = cnt;
        cfg.run = 1'b1;
        ext_en = 1'b1;
        cyc(18);
        chk(cnt - c0, 16'h1);
        rate(64, 16'h8);
        sleep = 1'b1;
        cyc(8);
        rate(64, 16'h0);
        cfg.skip_sync = 1'b1;
        cyc(16);
        rate(64, 16'h8);
        cfg.run = 1'b0;
        acc(1'b1, 1'b1, 8'hff);
        acc(1'b1, 1'b0, 8'hff);
        cfg.run = 1'b1;
        seen = 0;
        repeat (24) begin
            cyc(1);
            if (wake === 1'b1) begin
                seen++;
            end
        end
        chk(16'(seen), 16'h1);
        chk({15'h0, ovf}, 16'h1);
        sleep = 1'b0;
        lp_en = 1'b1;
        cyc(16);
        cfg.clk_src = GT_SRC_LPOSC;
        ext_en = 1'b0;
        cyc(16);
        rate(64, 16'h8);
        lp_en = 1'b0;
    endtask
    task automatic t_reset;
        cfg.clk_src = GT_SRC_RAW;
        cyc(2);
        nrst = 1'b0;
        cyc(2);
        chk(cnt, 16'h0);
        chk({6'h0, wake, ovf, rdata}, 16'h0);
        nrst = 1'b1;
        cyc(2);
        chk(cnt, 16'h2);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up;
        end
    end
    initial begin
        cyc(6);
        nrst = 1'b1;
        cyc(2);
        t_rates;
        t_gate;
        t_wide;
        t_ovf;
        t_ext;
        t_reset;
        wrap_up;
    end
endmodule
